// ### design/vsc_pkg.sv
package vsc_pkg;
  // command codes on the management link
  localparam logic [7:0] CMD_MODE = 8'h20;
  localparam logic [7:0] CMD_SETPOINT = 8'h21;
  localparam logic [7:0] CMD_OFFSET = 8'h22;
  localparam logic [7:0] CMD_CEILING = 8'h24;
  localparam logic [7:0] CMD_MARGIN_HI = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LO = 8'h26;
  localparam logic [7:0] CMD_SLEW = 8'h27;
  // values after reset
  localparam logic [15:0] RST_SETPOINT = 16'h0133;
  localparam logic [15:0] RST_CEILING = 16'h1c00;
  localparam logic [15:0] RST_MARGIN_HI = 16'h0142;
  localparam logic [15:0] RST_MARGIN_LO = 16'h0123;
  localparam logic [15:0] RST_SLEW = 16'he002;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  // read-only mode byte: unsigned format, exponent -9
  localparam logic [7:0] MODE_BYTE = 8'h17;
  // slew field layout
  localparam int SLEW_EXP_MSB = 15;
  localparam int SLEW_EXP_LSB = 11;
  localparam int SLEW_MANT_MSB = 10;
  localparam logic [4:0] SLEW_EXP = 5'h1c;
  localparam logic [10:0] SLEW_MANT_MIN = 11'h001;
  localparam logic [10:0] SLEW_MANT_MAX = 11'h020;
  // ramp timing: one mantissa unit is 1/16 mV/us, one lsb 2^-9 V
  localparam int CLK_MHZ = 125;
  localparam int SLEW_UNIT_UV_NUM = 1000;
  localparam int SLEW_UNIT_DEN = 16;
  localparam int LSB_PER_V = 512;
  // per cycle: acc += mant*ADD, step one lsb each RAMP_DEN
  localparam int RAMP_ADD = LSB_PER_V / SLEW_UNIT_DEN;
  localparam int RAMP_DEN = SLEW_UNIT_UV_NUM * CLK_MHZ;
  localparam logic [17:0] RAMP_DEN_W = 18'(RAMP_DEN);
  localparam int RAMP_SHIFT = $clog2(RAMP_ADD);
  // operating point chosen by the operation command
  typedef enum logic [1:0] {
    VSC_NOMINAL = 2'h0,
    VSC_MARGIN_LOW = 2'h1,
    VSC_MARGIN_HIGH = 2'h2
  } vsc_margin_t;
  // request carried from link domain to core domain
  typedef struct packed {
    logic rd;
    logic [7:0] cmd;
    logic [15:0] data;
  } vsc_req_t;
endpackage

// ### design/vsc_setpoint_ctrl.sv
`timescale 1ns/1ps
module vsc_setpoint_ctrl (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  input wire logic i_link_clk,
  input wire logic i_link_rstn,
  input wire logic i_link_wr,
  input wire logic i_link_rd,
  input wire logic [7:0] i_link_cmd,
  input wire logic [15:0] i_link_wdata,
  input wire vsc_pkg::vsc_margin_t i_margin_sel,
  input wire logic i_conv_on,
  input wire logic [1:0] i_scale_sel,
  input wire logic [15:0] i_factory_trim,
  output logic o_link_busy,
  output logic o_link_rd_valid,
  output logic [7:0] o_link_rd_byte,
  output logic [15:0] o_target,
  output logic o_ramping,
  output logic o_rate_err,
  output logic [15:0] o_slew_rate
);
  import vsc_pkg::*;

  // ---------------- link domain ----------------
  vsc_req_t link_req_r; // held stable until core acknowledges
  logic link_req_tog_r; // flips once per request
  logic link_busy_r; // request in flight
  logic link_ack_s1_r; // sync stage one, read only by stage two
  logic link_ack_s2_r; // synchronised acknowledge toggle
  logic link_ack_seen_r; // last acknowledge consumed
  logic link_hi_pend_r; // high byte still to deliver
  logic link_rd_valid_r; // byte strobe
  logic [7:0] link_rd_byte_r; // byte out
  logic link_ack_new; // acknowledge arrived

  // ---------------- core domain ----------------
  logic core_req_s1_r; // sync stage one
  logic core_req_s2_r; // synchronised request toggle
  logic core_req_s3_r; // previous value for change detect
  logic core_ack_tog_r; // answer toggle back to link
  logic [15:0] core_rd_data_r; // held until next request
  logic core_new_req; // a request is waiting
  logic [15:0] setpoint_r; // nominal setpoint
  logic [15:0] offset_r; // signed trim
  logic [15:0] ceiling_r; // upper limit
  logic [15:0] margin_hi_r; // margin-high setpoint
  logic [15:0] margin_lo_r; // margin-low setpoint
  logic [15:0] slew_r; // slew rate, exponent and mantissa
  logic trim_loaded_r; // factory trim taken
  logic rate_err_r; // one-cycle reject pulse
  logic [15:0] cur_r; // ramped target
  logic [17:0] acc_r; // fractional ramp accumulator
  logic ramping_r; // ramp in progress
  logic [15:0] sel_val; // setpoint chosen by margin state
  logic signed [19:0] trim_ext; // scaled offset in lsb units
  logic signed [19:0] sum; // setpoint plus offset
  logic [15:0] goal; // limited target
  logic [17:0] acc_sum; // accumulator plus this cycle's step
  logic [17:0] step_add; // per-cycle increment
  logic slew_ok; // slew write is acceptable

  // link: accept a request, then wait for the answer
  assign link_ack_new = link_busy_r && (link_ack_s2_r != link_ack_seen_r);

  // link: request capture and handshake bookkeeping
  always_ff @(posedge i_link_clk or negedge i_link_rstn) begin
    if (!i_link_rstn) begin
      link_req_r <= '0;
      link_req_tog_r <= 1'b0;
      link_busy_r <= 1'b0;
      link_ack_seen_r <= 1'b0;
    end else begin
      if (!link_busy_r && (i_link_wr || i_link_rd)) begin
        // write wins when both strobes come together
        link_req_r.rd <= i_link_rd & ~i_link_wr;
        link_req_r.cmd <= i_link_cmd;
        link_req_r.data <= i_link_wdata;
        link_req_tog_r <= ~link_req_tog_r;
        link_busy_r <= 1'b1;
      end else if (link_ack_new) begin
        link_ack_seen_r <= link_ack_s2_r;
        link_busy_r <= 1'b0;
      end
    end
  end

  // link: acknowledge synchroniser
  always_ff @(posedge i_link_clk or negedge i_link_rstn) begin
    if (!i_link_rstn) begin
      link_ack_s1_r <= 1'b0;
      link_ack_s2_r <= 1'b0;
    end else begin
      link_ack_s1_r <= core_ack_tog_r;
      link_ack_s2_r <= link_ack_s1_r;
    end
  end

  // link: read answer, low byte then high byte
  always_ff @(posedge i_link_clk or negedge i_link_rstn) begin
    if (!i_link_rstn) begin
      link_rd_valid_r <= 1'b0;
      link_rd_byte_r <= 8'h00;
      link_hi_pend_r <= 1'b0;
    end else if (link_hi_pend_r) begin
      link_rd_valid_r <= 1'b1;
      link_rd_byte_r <= core_rd_data_r[15:8];
      link_hi_pend_r <= 1'b0;
    end else if (link_ack_new && link_req_r.rd) begin
      // core data is stable: it only changes on a new request
      link_rd_valid_r <= 1'b1;
      link_rd_byte_r <= core_rd_data_r[7:0];
      link_hi_pend_r <= 1'b1;
    end else begin
      link_rd_valid_r <= 1'b0;
    end
  end

  assign o_link_busy = link_busy_r;
  assign o_link_rd_valid = link_rd_valid_r;
  assign o_link_rd_byte = link_rd_byte_r;

  // core: request toggle synchroniser and change detect
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      core_req_s1_r <= 1'b0;
      core_req_s2_r <= 1'b0;
      core_req_s3_r <= 1'b0;
    end else if (i_clk_en) begin
      core_req_s1_r <= link_req_tog_r;
      core_req_s2_r <= core_req_s1_r;
      core_req_s3_r <= core_req_s2_r;
    end
  end

  assign core_new_req = core_req_s2_r ^ core_req_s3_r;

  // slew write check: fixed exponent, mantissa within span
  assign slew_ok =
    (link_req_r.data[SLEW_EXP_MSB:SLEW_EXP_LSB] == SLEW_EXP) &&
    (link_req_r.data[SLEW_MANT_MSB:0] >= SLEW_MANT_MIN) &&
    (link_req_r.data[SLEW_MANT_MSB:0] <= SLEW_MANT_MAX);

  // core: register writes; unknown commands are dropped
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      setpoint_r <= RST_SETPOINT;
      ceiling_r <= RST_CEILING;
      margin_hi_r <= RST_MARGIN_HI;
      margin_lo_r <= RST_MARGIN_LO;
      slew_r <= RST_SLEW;
      rate_err_r <= 1'b0;
    end else if (i_clk_en) begin
      rate_err_r <= 1'b0;
      if (core_new_req && !link_req_r.rd) begin
        case (link_req_r.cmd)
          // span is the host's to keep, stored as given
          CMD_SETPOINT: setpoint_r <= link_req_r.data;
          CMD_CEILING: ceiling_r <= link_req_r.data;
          CMD_MARGIN_HI: margin_hi_r <= link_req_r.data;
          CMD_MARGIN_LO: margin_lo_r <= link_req_r.data;
          CMD_SLEW: begin
            if (slew_ok) begin
              slew_r <= link_req_r.data;
            end else begin
              rate_err_r <= 1'b1;
            end
          end
          default: begin
            // offset and mode handled elsewhere
          end
        endcase
      end
    end
  end

  // core: offset register, loaded with factory trim after reset
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      offset_r <= RST_OFFSET;
      trim_loaded_r <= 1'b0;
    end else if (i_clk_en) begin
      if (!trim_loaded_r) begin
        // caught after release, not under reset
        offset_r <= i_factory_trim;
        trim_loaded_r <= 1'b1;
      end else if (core_new_req && !link_req_r.rd &&
                   link_req_r.cmd == CMD_OFFSET) begin
        // host already folded the factory trim into the value
        offset_r <= link_req_r.data;
      end
    end
  end

  // core: read mux and answer toggle
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      core_rd_data_r <= 16'h0000;
      core_ack_tog_r <= 1'b0;
    end else if (i_clk_en && core_new_req) begin
      core_ack_tog_r <= ~core_ack_tog_r;
      if (link_req_r.rd) begin
        case (link_req_r.cmd)
          CMD_MODE: core_rd_data_r <= {8'h00, MODE_BYTE};
          CMD_SETPOINT: core_rd_data_r <= setpoint_r;
          CMD_OFFSET: core_rd_data_r <= offset_r;
          CMD_CEILING: core_rd_data_r <= ceiling_r;
          CMD_MARGIN_HI: core_rd_data_r <= margin_hi_r;
          CMD_MARGIN_LO: core_rd_data_r <= margin_lo_r;
          CMD_SLEW: core_rd_data_r <= slew_r;
          default: core_rd_data_r <= 16'h0000;
        endcase
      end
    end
  end

  // target: pick operating point, add scaled trim, limit
  always_comb begin
    case (i_margin_sel)
      VSC_MARGIN_HIGH: sel_val = margin_hi_r;
      VSC_MARGIN_LOW: sel_val = margin_lo_r;
      default: sel_val = setpoint_r;
    endcase
    // dividing by 1, 0.5, 0.25, 0.125 is a left shift of 0..3
    trim_ext = {{4{offset_r[15]}}, offset_r} <<< i_scale_sel;
    sum = $signed({4'h0, sel_val}) + trim_ext;
    if (sum < 0) begin
      goal = 16'h0000;
    end else if (sum > $signed({4'h0, ceiling_r})) begin
      goal = ceiling_r;
    end else begin
      goal = sum[15:0];
    end
  end

  // ramp increment: mantissa times lsb-per-unit ratio
  assign step_add = 18'({slew_r[5:0], {RAMP_SHIFT{1'b0}}});
  assign acc_sum = acc_r + step_add;

  // ramp: step one lsb each time the accumulator wraps
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cur_r <= RST_SETPOINT;
      acc_r <= 18'h00000;
      ramping_r <= 1'b0;
    end else if (i_clk_en) begin
      ramping_r <= i_conv_on && (cur_r != goal);
      if (!i_conv_on) begin
        // turn-on and turn-off ramps belong to soft start
        cur_r <= goal;
        acc_r <= 18'h00000;
      end else if (cur_r > ceiling_r) begin
        // ceiling lowered mid-ramp: cut at once
        cur_r <= ceiling_r;
        acc_r <= 18'h00000;
      end else if (cur_r == goal) begin
        acc_r <= 18'h00000;
      end else if (acc_sum >= RAMP_DEN_W) begin
        acc_r <= acc_sum - RAMP_DEN_W;
        if (goal > cur_r) begin
          cur_r <= cur_r + 16'h0001;
        end else begin
          cur_r <= cur_r - 16'h0001;
        end
      end else begin
        acc_r <= acc_sum;
      end
    end
  end

  assign o_target = cur_r;
  assign o_ramping = ramping_r;
  assign o_rate_err = rate_err_r;
  assign o_slew_rate = slew_r;
endmodule

// ### verification/test_vsc_setpoint_ctrl.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t got %h exp %h", $time, (a), (b)); end end
module test_vsc_setpoint_ctrl;
  import vsc_pkg::*;
  localparam logic [15:0] TRIM = 16'h0004; // factory offset fed in
  logic i_clock = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_rstn = 1'b0;
  vsc_margin_t i_margin_sel = VSC_NOMINAL;
  logic i_conv_on = 1'b0;
  logic i_clk_en = 1'b1; // core freeze control
  logic [1:0] i_scale_sel = 2'h0;
  logic wr, rd, busy, rd_valid, ramping, rate_err;
  logic [7:0] cmd, rd_byte;
  logic [15:0] wdata, target, slew, rdata;
  int n_fail = 0;
  int num_checks = 0;
  int n_err = 0; // rejected slew writes seen
  int cyc;
  logic [7:0] rcmd [8] = '{CMD_MODE, CMD_SETPOINT, CMD_OFFSET, 8'h23,
    CMD_CEILING, CMD_MARGIN_HI, CMD_MARGIN_LO, CMD_SLEW};
  logic [15:0] rexp [8] = '{16'h0017, 16'h0133, TRIM, 16'h0000,
    16'h1c00, 16'h0142, 16'h0123, 16'he002};
  vsc_margin_t msel [3] = '{VSC_MARGIN_HIGH, VSC_MARGIN_LOW,
    vsc_margin_t'(2'h3)};
  logic [15:0] mexp [3] = '{16'h0144, 16'h0125, 16'h0135};
  logic [15:0] bad [3] = '{16'hd802, 16'he000, 16'he021};
  always #4 i_clock = ~i_clock;
  // link clock, phase unrelated to the core clock
  always #15 i_link_clk = ~i_link_clk;
  always @(posedge i_clock) if (rate_err === 1'b1) n_err++;
  vsc_setpoint_ctrl dut (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_clk_en(i_clk_en), .i_link_clk(i_link_clk), .i_link_rstn(i_rstn),
    .i_link_wr(wr), .i_link_rd(rd), .i_link_cmd(cmd),
    .i_link_wdata(wdata), .i_margin_sel(i_margin_sel),
    .i_conv_on(i_conv_on), .i_scale_sel(i_scale_sel),
    .i_factory_trim(TRIM), .o_link_busy(busy),
    .o_link_rd_valid(rd_valid), .o_link_rd_byte(rd_byte),
    .o_target(target), .o_ramping(ramping), .o_rate_err(rate_err),
    .o_slew_rate(slew));
  vsc_host_model host (.i_link_clk(i_link_clk), .i_busy(busy),
    .i_rd_byte(rd_byte), .o_wr(wr), .o_rd(rd), .o_cmd(cmd),
    .o_wdata(wdata));
  task automatic wr16(input logic [7:0] c, input logic [15:0] d);
    host.xfer(1'b0, c, d, rdata);
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
    host.xfer(1'b1, c, 16'h0000, rdata);
    `CHK(rdata, e);
  endtask
  // let the goal reach the target register
  task automatic settle;
    repeat (6) @(posedge i_clock);
    @(negedge i_clock);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, well past the ramp's few thousand cycles
  initial begin
    repeat (40000) @(posedge i_clock);
    n_fail++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge i_clock);
    i_rstn <= 1'b1;
    foreach (rcmd[i]) rd_chk(rcmd[i], rexp[i]);
    wr16(CMD_MODE, 16'h1234);
    rd_chk(CMD_MODE, 16'h0017);
    settle;
    `CHK(target, 16'h0137);
    for (int s = 1; s < 4; s += 2) begin
      @(posedge i_clock);
      i_scale_sel <= 2'(s);
      settle;
      `CHK(target, 16'h0133 + (TRIM << s));
    end
    @(posedge i_clock);
    i_scale_sel <= 2'h0;
    wr16(CMD_OFFSET, TRIM + 16'hfffe);
    rd_chk(CMD_OFFSET, 16'h0002);
    foreach (msel[i]) begin
      @(posedge i_clock);
      i_margin_sel <= msel[i];
      settle;
      `CHK(target, mexp[i]);
    end
    wr16(CMD_CEILING, 16'h0130);
    rd_chk(CMD_CEILING, 16'h0130);
    @(posedge i_clock);
    i_margin_sel <= VSC_MARGIN_HIGH;
    settle;
    `CHK(target, 16'h0130);
    wr16(CMD_CEILING, 16'h1c00);
    @(posedge i_clock);
    i_margin_sel <= VSC_NOMINAL;
    foreach (bad[i]) wr16(CMD_SLEW, bad[i]);
    settle;
    `CHK(n_err, 3);
    `CHK(slew, 16'he002);
    wr16(CMD_SLEW, 16'he020);
    rd_chk(CMD_SLEW, 16'he020);
    @(posedge i_clock);
    i_conv_on <= 1'b1;
    settle;
    `CHK(target, 16'h0135);
    wr16(CMD_SETPOINT, 16'h0145);
    // 18 steps at 2 mV/us, about 122 cycles each
    cyc = 0;
    while (target !== 16'h0147 && cyc < 4000) begin
      @(negedge i_clock);
      cyc++;
      if (cyc == 1000) `CHK(ramping, 1'b1);
    end
    `CHK(cyc > 1900 && cyc < 2400, 1'b1);
    settle;
    `CHK(ramping, 1'b0);
    @(posedge i_clock);
    i_conv_on <= 1'b0;
    wr16(CMD_SETPOINT, 16'h0133);
    settle;
    `CHK(target, 16'h0135);
    // frozen core must not follow a margin change
    @(posedge i_clock);
    i_clk_en <= 1'b0;
    i_margin_sel <= VSC_MARGIN_HIGH;
    settle;
    `CHK(target, 16'h0135);
    @(posedge i_clock);
    i_clk_en <= 1'b1;
    settle;
    `CHK(target, 16'h0144);
    `CHK(host.n_hang, 0);
    end_sim;
  end
endmodule

// ### verification/vsc_host_model.sv
`timescale 1ns/1ps
module vsc_host_model (
  input wire logic i_link_clk,
  input wire logic i_busy,
  input wire logic [7:0] i_rd_byte,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_cmd,
  output logic [15:0] o_wdata
);
  int n_hang = 0; // waits cut by the bound
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_cmd = 8'h00;
    o_wdata = 16'h0000;
  end
  // one transfer; strobe held up to the taking edge only
  task automatic xfer(input logic rd, input logic [7:0] cmd,
      input logic [15:0] wd, output logic [15:0] rdata);
    int n;
    n = 0;
    rdata = 16'h0000;
    @(posedge i_link_clk);
    o_wr <= !rd;
    o_rd <= rd;
    o_cmd <= cmd;
    o_wdata <= wd;
    @(posedge i_link_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    // released lines show the inverse, not a stale copy
    o_cmd <= ~cmd;
    o_wdata <= ~wd;
    @(negedge i_link_clk);
    while (i_busy !== 1'b0 && n < 200) begin
      @(negedge i_link_clk);
      n++;
    end
    if (rd) begin
      rdata[7:0] = i_rd_byte;
      @(negedge i_link_clk);
      rdata[15:8] = i_rd_byte;
    end
    if (n >= 200) n_hang++;
  endtask
endmodule

// ### verification/vsc_setpoint_ctrl_sva.sv
`timescale 1ns/1ps
module vsc_setpoint_ctrl_sva (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_link_clk,
  input wire logic i_link_rstn,
  input wire logic i_link_wr,
  input wire logic i_link_rd,
  input wire logic i_conv_on,
  input wire logic o_link_busy,
  input wire logic o_link_rd_valid,
  input wire logic [15:0] o_target,
  input wire logic o_ramping,
  input wire logic o_rate_err,
  input wire logic [15:0] o_slew_rate
);
  import vsc_pkg::*;
  // second byte, then the strobe drops
  sequence s_two_bytes;
    o_link_rd_valid ##1 !o_link_rd_valid;
  endsequence
  a_err_one_cycle: assert property (@(posedge i_clock)
    disable iff (!i_rstn) o_rate_err |=> !o_rate_err)
    else $error("rate error pulse too long");
  a_err_keeps_slew: assert property (@(posedge i_clock)
    disable iff (!i_rstn) o_rate_err |-> $stable(o_slew_rate))
    else $error("rejected slew write changed the rate");
  a_slew_exp_fixed: assert property (@(posedge i_clock)
    disable iff (!i_rstn) o_slew_rate[15:11] == SLEW_EXP)
    else $error("slew exponent not fixed");
  a_slew_mant_span: assert property (@(posedge i_clock)
    disable iff (!i_rstn) o_slew_rate[10:0] >= SLEW_MANT_MIN &&
    o_slew_rate[10:0] <= SLEW_MANT_MAX)
    else $error("slew mantissa out of span");
  a_off_no_ramp: assert property (@(posedge i_clock)
    disable iff (!i_rstn) !i_conv_on [*3] |-> !o_ramping)
    else $error("ramping while converter off");
  a_ramp_one_lsb: assert property (@(posedge i_clock)
    disable iff (!i_rstn) i_conv_on && $past(i_conv_on) &&
    o_target > $past(o_target) |-> o_target == $past(o_target) + 16'h1)
    else $error("ramp stepped more than one lsb");
  a_take_sets_busy: assert property (@(posedge i_link_clk)
    disable iff (!i_link_rstn)
    (i_link_wr || i_link_rd) && !o_link_busy |=> o_link_busy)
    else $error("request taken without busy");
  a_read_pair: assert property (@(posedge i_link_clk)
    disable iff (!i_link_rstn) $rose(o_link_rd_valid) |=> s_two_bytes)
    else $error("read did not give exactly two bytes");
  a_byte_on_free: assert property (@(posedge i_link_clk)
    disable iff (!i_link_rstn) $rose(o_link_rd_valid) |-> $fell(o_link_busy))
    else $error("first byte not on busy release");
endmodule
bind vsc_setpoint_ctrl vsc_setpoint_ctrl_sva u_sva (.i_clock, .i_rstn,
  .i_link_clk, .i_link_rstn, .i_link_wr, .i_link_rd, .i_conv_on,
  .o_link_busy, .o_link_rd_valid, .o_target, .o_ramping, .o_rate_err,
  .o_slew_rate);
